// ===== spip_map.svh
// register offsets, field positions, reset values and divisors of the serial port
// Operation
// - role field picks master clock or slave
// - port-on clear releases pins, stops port
// - polarity bit sets clock idle level
// - edge bit with polarity picks capture edge
// - order bit picks lsb or msb first
// - select-enable bit hands select pin to port
// - data write during transfer dropped, collision flagged
// - hardware sets done flag, software clears it
// - master data write starts full-duplex transfer
// - slave shifts on external master clock pulses
// - select asserted before any clock pulse
// - slave first bit ready at select
// - port keeps running in idle mode
// - slave without select-enable is always selected
// - unimplemented control bits read as zero
// - build option can disable select and collision
// - enabled idle pins: out high, clock idle; a slave without select-enable drives its first bit instead
`ifndef SPIP_MAP_SVH
`define SPIP_MAP_SVH
`define SPIP_OFF_CTRL0 5'h00
`define SPIP_OFF_CTRL1 5'h04
`define SPIP_OFF_DATA 5'h08
`define SPIP_OFF_IRQ_STAT 5'h0C
`define SPIP_OFF_IRQ_EN 5'h10
`define SPIP_OFF_IRQ_CLR 5'h14
`define SPIP_C0_PORT_ON 1
`define SPIP_C1_POL 5
`define SPIP_C1_EDGE 4
`define SPIP_C1_ORDER 3
`define SPIP_C1_SELEN 2
`define SPIP_C1_WCOL 1
`define SPIP_C1_DONE 0
`define SPIP_IRQ_DONE 0
`define SPIP_IRQ_WCOL 1
`define SPIP_RST_ROLE 3'h7
`define SPIP_ROLE_DIV4 3'h0
`define SPIP_ROLE_DIV16 3'h1
`define SPIP_ROLE_DIV64 3'h2
`define SPIP_ROLE_SUB 3'h3
`define SPIP_ROLE_TIMER 3'h4
`define SPIP_ROLE_SLAVE 3'h5
`define SPIP_HALF_DIV4 6'h02
`define SPIP_HALF_DIV16 6'h08
`define SPIP_HALF_DIV64 6'h20
`define SPIP_LAST_EDGE 4'hF
`define SPIP_LAST_BIT 4'h7
`endif

// ===== spip_pkg.sv
// types shared by the serial port and its bench
package spip_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_RUN} spip_state_e;
	typedef logic [7:0] spip_byte_t;
	typedef struct packed {
		logic [4:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} spip_avs_req_s;
	typedef struct packed {
		logic serial_out;
		logic serial_out_en;
		logic clock_drive;
		logic clock_en;
		logic select_n_drive;
		logic select_n_en;
	} spip_pins_s;
endpackage : spip_pkg

// ===== spip_port.sv
// four-wire serial port, master or slave, with avalon register slave and interrupt
`timescale 1ns/100ps
`include "spip_map.svh"
module spip_port #(
	parameter bit SEL_COL_OPT = 1'b1
) (
	input wire logic clock,
	input wire logic reset,
	input wire spip_pkg::spip_avs_req_s avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sub_clock_edge,
	input wire logic period_match,
	input wire logic serial_in,
	input wire logic serial_clock_level,
	input wire logic select_n_level,
	output spip_pkg::spip_pins_s pins,
	output logic irq
);
	import spip_pkg::*;

	logic [2:0] role_ff;
	logic port_on_ff;
	logic pol_ff;
	logic edge_ff;
	logic order_ff;
	logic selen_ff;
	logic wcol_ff;
	logic done_ff;
	spip_byte_t data_ff;
	spip_byte_t tx_ff;
	spip_byte_t rx_ff;
	spip_byte_t nxt_rx;
	spip_byte_t done_word;
	spip_byte_t wdata8;
	logic [3:0] cap_cnt_ff;
	logic [3:0] half_cnt_ff;
	logic [5:0] div_cnt_ff;
	spip_state_e state_ff;
	logic sck_ff;
	logic prev_sck_ff;
	logic slv_busy_ff;
	logic ack_ff;
	logic [1:0] irq_stat_ff;
	logic [1:0] irq_en_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic req;
	logic wr_go;
	logic wr_data;
	logic wr_c0;
	logic wr_c1;
	logic sel_en_eff;
	logic is_master;
	logic is_slave;
	logic busy;
	logic start;
	logic collide;
	logic half_tick;
	logic m_edge;
	logic m_done;
	logic s_on;
	logic s_change;
	logic s_lead;
	logic s_trail;
	logic s_cap;
	logic s_done;
	logic lead;
	logic trail;
	logic cap;
	logic shf_go;
	logic xfer_done;

	function automatic logic [5:0] half_len(input logic [2:0] role);
		case (role)
			`SPIP_ROLE_DIV4: half_len = `SPIP_HALF_DIV4;
			`SPIP_ROLE_DIV16: half_len = `SPIP_HALF_DIV16;
			default: half_len = `SPIP_HALF_DIV64;
		endcase
	endfunction : half_len

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
		hit = (addr == off);
	endfunction : hit

	// bus slave: every access waits one cycle, so reads come from a flop
	assign req = avs_req.read | avs_req.write;
	assign avs_waitrequest = req & ~ack_ff;
	assign avs_readdata = rdata_ff;
	assign wr_go = avs_req.write & ack_ff & avs_req.byteenable[0];
	assign wdata8 = avs_req.writedata[7:0];
	assign wr_data = wr_go & hit(avs_req.address, `SPIP_OFF_DATA);
	assign wr_c0 = wr_go & hit(avs_req.address, `SPIP_OFF_CTRL0);
	assign wr_c1 = wr_go & hit(avs_req.address, `SPIP_OFF_CTRL1);

	always_ff @(posedge clock) begin
		if (reset) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req & ~ack_ff;
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (avs_req.address)
			`SPIP_OFF_CTRL0: nxt_rdata[7:0] = {role_ff, 3'h0, port_on_ff, 1'h0};
			`SPIP_OFF_CTRL1: nxt_rdata[7:0] = {2'h0, pol_ff, edge_ff, order_ff, selen_ff,
				wcol_ff, done_ff};
			`SPIP_OFF_DATA: nxt_rdata[7:0] = data_ff;
			`SPIP_OFF_IRQ_STAT: nxt_rdata[1:0] = irq_stat_ff;
			`SPIP_OFF_IRQ_EN: nxt_rdata[1:0] = irq_en_ff;
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_req.read & ~ack_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// control registers; flags handled separately
	always_ff @(posedge clock) begin
		if (reset) begin
			role_ff <= `SPIP_RST_ROLE;
			port_on_ff <= 1'b0;
		end else if (wr_c0) begin
			role_ff <= wdata8[7:5];
			port_on_ff <= wdata8[`SPIP_C0_PORT_ON];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pol_ff <= 1'b0;
			edge_ff <= 1'b0;
			order_ff <= 1'b0;
			selen_ff <= 1'b0;
		end else if (wr_c1) begin
			pol_ff <= wdata8[`SPIP_C1_POL];
			edge_ff <= wdata8[`SPIP_C1_EDGE];
			order_ff <= wdata8[`SPIP_C1_ORDER];
			selen_ff <= wdata8[`SPIP_C1_SELEN];
		end
	end

	// mode decode; reserved role codes leave the port inert
	assign sel_en_eff = SEL_COL_OPT & selen_ff;
	assign is_master = port_on_ff & (role_ff <= `SPIP_ROLE_TIMER);
	assign is_slave = port_on_ff & (role_ff == `SPIP_ROLE_SLAVE);
	assign busy = (state_ff != ST_IDLE) | slv_busy_ff;
	assign start = wr_data & ~busy & is_master & (state_ff == ST_IDLE);
	assign collide = wr_data & busy;

	// half-period tick; no idle-mode gate, the divider is held at zero while the sequencer is in ST_IDLE
	always_ff @(posedge clock) begin
		if (reset || state_ff == ST_IDLE) begin
			div_cnt_ff <= 6'h00;
		end else if (div_cnt_ff == 6'(half_len(role_ff) - 6'h01)) begin
			div_cnt_ff <= 6'h00;
		end else begin
			div_cnt_ff <= 6'(div_cnt_ff + 6'h01);
		end
	end

	always_comb begin
		case (role_ff)
			`SPIP_ROLE_DIV4,
			`SPIP_ROLE_DIV16,
			`SPIP_ROLE_DIV64: half_tick = (div_cnt_ff == 6'(half_len(role_ff) - 6'h01));
			`SPIP_ROLE_SUB: half_tick = sub_clock_edge;
			`SPIP_ROLE_TIMER: half_tick = period_match;
			default: half_tick = 1'b0;
		endcase
	end

	// master sequencer: one half period of select setup, then sixteen edges
	always_ff @(posedge clock) begin
		if (reset || !is_master) begin
			state_ff <= ST_IDLE;
			half_cnt_ff <= 4'h0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (start) begin
						state_ff <= ST_SETUP;
						half_cnt_ff <= 4'h0;
					end
				end
				ST_SETUP: begin
					if (half_tick) begin
						state_ff <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (half_tick) begin
						half_cnt_ff <= 4'(half_cnt_ff + 4'h1);
						if (half_cnt_ff == `SPIP_LAST_EDGE) begin
							state_ff <= ST_IDLE;
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sck_ff <= 1'b1;
		end else if (state_ff != ST_RUN) begin
			sck_ff <= ~pol_ff;
		end else if (half_tick) begin
			sck_ff <= ~sck_ff;
		end
	end

	assign m_edge = (state_ff == ST_RUN) & half_tick;
	assign m_done = m_edge & (half_cnt_ff == `SPIP_LAST_EDGE);

	// slave edges; pin levels are taken as already synchronous
	assign s_on = is_slave & (~sel_en_eff | ~select_n_level);
	assign s_change = serial_clock_level ^ prev_sck_ff;
	assign s_lead = s_on & s_change & (prev_sck_ff == ~pol_ff);
	assign s_trail = s_on & s_change & (prev_sck_ff == pol_ff);
	assign s_cap = edge_ff ? s_lead : s_trail;
	assign s_done = s_cap & (cap_cnt_ff == `SPIP_LAST_BIT);

	always_ff @(posedge clock) begin
		if (reset) begin
			prev_sck_ff <= 1'b1;
		end else begin
			prev_sck_ff <= serial_clock_level;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || !s_on || s_done) begin
			slv_busy_ff <= 1'b0;
		end else if (s_lead | s_trail) begin
			slv_busy_ff <= 1'b1;
		end
	end

	// shared shifter; a shift edge before the first capture is skipped
	// so the bit preset at load or select is not lost
	assign lead = (m_edge & ~half_cnt_ff[0]) | s_lead;
	assign trail = (m_edge & half_cnt_ff[0]) | s_trail;
	assign cap = edge_ff ? lead : trail;
	assign shf_go = (edge_ff ? trail : lead) & (cap_cnt_ff != 4'h0);
	assign xfer_done = m_done | s_done;
	assign nxt_rx = order_ff ? {rx_ff[6:0], serial_in} : {serial_in, rx_ff[7:1]};
	assign done_word = cap ? nxt_rx : rx_ff;

	always_ff @(posedge clock) begin
		if (reset || !port_on_ff || start || xfer_done || (is_slave && !s_on)) begin
			cap_cnt_ff <= 4'h0;
		end else if (cap) begin
			cap_cnt_ff <= 4'(cap_cnt_ff + 4'h1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rx_ff <= 8'h00;
		end else if (cap) begin
			rx_ff <= nxt_rx;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			tx_ff <= 8'h00;
		end else if (wr_data & ~busy) begin
			tx_ff <= wdata8;
		end else if (xfer_done) begin
			tx_ff <= done_word;
		end else if (shf_go) begin
			tx_ff <= order_ff ? {tx_ff[6:0], 1'b0} : {1'b0, tx_ff[7:1]};
		end else if (is_slave & ~s_on) begin
			tx_ff <= data_ff;
		end
	end

	// a write while busy is dropped outright; only the collision flag and its interrupt status bit record it
	always_ff @(posedge clock) begin
		if (reset) begin
			data_ff <= 8'h00;
		end else if (xfer_done) begin
			data_ff <= done_word;
		end else if (wr_data & ~busy) begin
			data_ff <= wdata8;
		end
	end

	// flags: hardware set beats a same-cycle software clear
	always_ff @(posedge clock) begin
		if (reset) begin
			done_ff <= 1'b0;
		end else if (xfer_done) begin
			done_ff <= 1'b1;
		end else if (wr_c1 & ~wdata8[`SPIP_C1_DONE]) begin
			done_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wcol_ff <= 1'b0;
		end else if (collide & SEL_COL_OPT) begin
			wcol_ff <= 1'b1;
		end else if (wr_c1 & ~wdata8[`SPIP_C1_WCOL]) begin
			wcol_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			irq_en_ff <= 2'h0;
		end else if (wr_go & hit(avs_req.address, `SPIP_OFF_IRQ_EN)) begin
			irq_en_ff <= wdata8[1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			irq_stat_ff <= 2'h0;
		end else begin
			irq_stat_ff[`SPIP_IRQ_DONE] <= xfer_done | (irq_stat_ff[`SPIP_IRQ_DONE]
				& ~(wr_go & hit(avs_req.address, `SPIP_OFF_IRQ_CLR)
				& wdata8[`SPIP_IRQ_DONE]));
			irq_stat_ff[`SPIP_IRQ_WCOL] <= (collide & SEL_COL_OPT)
				| (irq_stat_ff[`SPIP_IRQ_WCOL] & ~(wr_go
				& hit(avs_req.address, `SPIP_OFF_IRQ_CLR) & wdata8[`SPIP_IRQ_WCOL]));
		end
	end

	assign irq = |(irq_stat_ff & irq_en_ff);

	// pins; all enables drop when the port is off
	always_comb begin
		pins.serial_out_en = port_on_ff;
		pins.serial_out = ((state_ff != ST_IDLE) | s_on)
			? (order_ff ? tx_ff[7] : tx_ff[0]) : 1'b1;
		pins.clock_en = is_master;
		pins.clock_drive = sck_ff;
		pins.select_n_en = is_master & sel_en_eff;
		pins.select_n_drive = (state_ff == ST_IDLE);
	end

	// checks
	logic [4:0] chk_tog_ff;
	logic chk_prev_ff;

	always_ff @(posedge clock) begin
		if (reset || start) begin
			chk_tog_ff <= 5'h00;
		end else if (pins.clock_drive != chk_prev_ff) begin
			chk_tog_ff <= 5'(chk_tog_ff + 5'h01);
		end
	end

	always_ff @(posedge clock) begin
		chk_prev_ff <= pins.clock_drive;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	chk_slave_no_drive: assert property (is_slave |-> !pins.clock_en && !pins.select_n_en)
		else $error("slave mode drives clock or select");
	chk_port_off_release: assert property (!port_on_ff |->
		!(pins.serial_out_en || pins.clock_en || pins.select_n_en))
		else $error("pins driven while port off");
	chk_idle_clock_level: assert property ((state_ff == ST_IDLE) && $past(state_ff == ST_IDLE)
		&& $stable(pol_ff) |-> pins.clock_drive == !pol_ff)
		else $error("idle clock level wrong");
	chk_capture_edge_dir: assert property (m_edge && cap |=>
		pins.clock_drive == !(pol_ff ^ edge_ff))
		else $error("master captures on wrong edge");
	chk_first_bit_order: assert property (start |=> pins.serial_out ==
		(order_ff ? $past(avs_req.writedata[7]) : $past(avs_req.writedata[0])))
		else $error("first output bit not per order");
	chk_select_pin_off: assert property (!sel_en_eff |-> !pins.select_n_en)
		else $error("select pin used while disabled");
	chk_collision_drop: assert property (collide && !xfer_done |=>
		data_ff == $past(data_ff) && (wcol_ff || !SEL_COL_OPT))
		else $error("colliding write not dropped or not flagged");
	chk_done_flag_set: assert property (xfer_done |=>
		done_ff && irq_stat_ff[`SPIP_IRQ_DONE])
		else $error("done flag not set");
	chk_select_before_clock: assert property (state_ff == ST_SETUP |->
		!pins.select_n_drive && pins.clock_drive == !pol_ff)
		else $error("clock moved before select");
	chk_sixteen_edges: assert property (m_done |=> ##1 chk_tog_ff == 5'h10
		&& pins.clock_drive == !pol_ff)
		else $error("master did not give eight pulses");
	chk_slave_always_sel: assert property (is_slave && !sel_en_eff |-> s_on)
		else $error("slave not selected without select enable");

	cov_master_word: cover property (m_done);
	cov_slave_word: cover property (s_done);
	cov_collision: cover property (collide);
	cov_irq_raise: cover property ($rose(irq));

endmodule : spip_port

// ===== spip_peer.sv
// external serial partner: answers the port as slave, or drives it as master
`timescale 1ns/100ps
module spip_peer (
	input wire logic clock,
	input wire spip_pkg::spip_pins_s pins,
	input wire logic pol,
	input wire logic edge_sel,
	input wire logic msb_first,
	input wire spip_pkg::spip_byte_t tx,
	output logic serial_in,
	output logic serial_clock_level,
	output logic select_n_level,
	output spip_pkg::spip_byte_t rx,
	output int toggles,
	output logic sel_err
);
	import spip_pkg::*;
	logic mm, sel_q, sck_q, so_q;
	int nb;
	function automatic int pos(input int k);
		return msb_first ? 7 - k : k;
	endfunction : pos
	// capture edge rises when polarity equals edge bit
	function automatic logic cap(input logic lvl);
		return lvl == (pol ~^ edge_sel);
	endfunction : cap
	initial begin
		{mm, so_q, nb, toggles, sel_err, serial_in, rx} = '0;
		{sel_q, sck_q, serial_clock_level, select_n_level} = 4'hF;
	end
	// slave side; works at the falling edge so the port's outputs have settled
	always @(negedge clock) begin
		if (!mm) begin
			serial_clock_level = !pol;
			select_n_level = 1'b1;
			// last edge comes with select release; data is the level held before the edge
			if (!sel_q && pins.clock_drive != sck_q) begin
				toggles++;
				if (cap(pins.clock_drive)) begin
					rx[pos(nb)] = so_q;
					nb++;
				end else if (nb > 0 && nb < 8) begin
					serial_in = tx[pos(nb)];
				end
			end else if (pins.select_n_drive) begin
				serial_in = ~serial_in; // no pull on the line, so never a stale level
			end else if (sel_q) begin
				sel_err = sel_err | (pins.clock_drive != !pol);
				toggles = 0;
				nb = 0;
				rx = '0;
				serial_in = tx[pos(0)];
			end
			sel_q = pins.select_n_drive;
			sck_q = pins.clock_drive;
			so_q = pins.serial_out;
		end
	end
	// master side: select first when use_sel is set, then 16 slow clock toggles
	task run_master(input logic use_sel);
		int k;
		mm = 1'b1;
		@(negedge clock);
		serial_clock_level = !pol;
		select_n_level = !use_sel;
		serial_in = tx[pos(0)];
		nb = 0;
		rx = '0;
		repeat (6) @(negedge clock);
		for (k = 0; k < 16; k++) begin
			serial_clock_level = ~serial_clock_level;
			if (cap(serial_clock_level)) begin
				rx[pos(nb)] = pins.serial_out;
				nb++;
			end else if (nb < 8) begin
				serial_in = tx[pos(nb)];
			end
			repeat (6) @(negedge clock);
		end
		select_n_level = 1'b1;
		mm = 1'b0;
	endtask : run_master
endmodule : spip_peer

// ===== tb.sv
// self-checking bench for the serial port
`timescale 1ns/100ps
`include "spip_map.svh"
module tb;
	import spip_pkg::*;
	logic clock, reset, sub_clock_edge, period_match, wreq, irq, sin, sck, seln;
	logic pol, edg, msb, serr;
	logic [31:0] rd, rv;
	spip_avs_req_s req;
	spip_pins_s pins;
	spip_byte_t ptx, prx, v;
	int tog, cyc, bad_count, checked, i;
	spip_port spip_port_i (.clock(clock), .reset(reset), .avs_req(req), .avs_readdata(rd),
		.avs_waitrequest(wreq), .sub_clock_edge(sub_clock_edge), .period_match(period_match),
		.serial_in(sin), .serial_clock_level(sck), .select_n_level(seln), .pins(pins), .irq(irq));
	spip_peer spip_peer_i (.clock(clock), .pins(pins), .pol(pol), .edge_sel(edg),
		.msb_first(msb), .tx(ptx), .serial_in(sin), .serial_clock_level(sck),
		.select_n_level(seln), .rx(prx), .toggles(tog), .sel_err(serr));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// half-period pulses for the sub clock and timer roles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		sub_clock_edge <= (cyc % 3 == 0);
		period_match <= (cyc % 5 == 0);
	end
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task acc(input logic w, input logic [4:0] a, input spip_byte_t d);
		@(posedge clock);
		req.address <= a;
		req.write <= w;
		req.read <= !w;
		req.writedata <= {24'h000000, d};
		// no fixed wait count; only the watchdog ends a stuck access
		@(posedge clock);
		while (wreq !== 1'b0) begin
			@(posedge clock);
		end
		rv = rd;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask : acc
	task wait_done;
		int n;
		n = 0;
		rv = '0;
		while (rv[0] !== 1'b1 && n < 400) begin
			acc(1'b0, `SPIP_OFF_CTRL1, 8'h00);
			n++;
		end
	endtask : wait_done
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (30000) @(posedge clock);
		bad_count++;
		$display("[ERR] watchdog expected finish seen hang");
		report_and_stop();
	end
	initial begin
		{cyc, bad_count, checked, sub_clock_edge, period_match, pol, edg, msb, ptx} = '0;
		req = '0;
		req.byteenable = 4'hF;
		reset = 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		acc(1'b0, `SPIP_OFF_CTRL0, 8'h00);
		chk("ctrl0 reset", rv, 32'hE0);
		chk("port off out en", pins.serial_out_en, 1'b0);
		chk("port off clk en", pins.clock_en, 1'b0);
		acc(1'b1, `SPIP_OFF_CTRL0, 8'hFF);
		acc(0, `SPIP_OFF_CTRL0, 8'h00);
		chk("ctrl0 unused", rv, 32'hE2);
		acc(1'b1, `SPIP_OFF_CTRL1, 8'hFF);
		acc(0, `SPIP_OFF_CTRL1, 8'h00);
		chk("ctrl1 unused", rv, 32'h3C);
		acc(1'b1, `SPIP_OFF_DATA, 8'h99);
		repeat (40) @(negedge clock);
		chk("reserved select", pins.select_n_drive, 1'b1);
		acc(0, `SPIP_OFF_CTRL1, 8'h00);
		chk("reserved done", rv[0], 1'b0);
		acc(1'b1, 5'h18, 8'hFF);
		acc(0, 5'h18, 8'h00);
		chk("unmapped", rv, 32'h0);
		$display("test registers finished");
		// every master clock source, with polarity, edge and order varied
		for (i = 0; i < 5; i++) begin
			pol = i[0];
			edg = i[1];
			msb = ~i[0];
			ptx = 8'h1D ^ (8'h4B * i[7:0]);
			v = 8'hC2 + i[7:0];
			acc(1'b1, `SPIP_OFF_CTRL0, {i[2:0], 5'b00010});
			acc(1'b1, `SPIP_OFF_CTRL1, {2'b00, pol, edg, msb, 3'b100});
			repeat (2) @(negedge clock);
			chk("clock idle", pins.clock_drive, !pol);
			chk("select en", pins.select_n_en, 1'b1);
			chk("out idle", pins.serial_out, 1'b1);
			acc(1'b1, `SPIP_OFF_DATA, v);
			if (i == 0) begin
				acc(1'b1, `SPIP_OFF_DATA, 8'h55);
			end
			wait_done();
			chk("done", rv[0], 1'b1);
			chk("collision", rv[1], i == 0);
			chk("toggles", tog, 16);
			chk("clock back idle", pins.clock_drive, !pol);
			chk("select first", serr, 1'b0);
			chk("sent", prx, v);
			acc(0, `SPIP_OFF_DATA, 8'h00);
			chk("received", rv, ptx);
			acc(1'b1, `SPIP_OFF_CTRL1, {2'b00, pol, edg, msb, 3'b100});
			acc(0, `SPIP_OFF_CTRL1, 8'h00);
			chk("flags cleared", rv[1:0], 2'b00);
		end
		$display("test master finished");
		acc(0, `SPIP_OFF_IRQ_STAT, 8'h00);
		chk("irq status", rv, 32'h3);
		chk("irq masked", irq, 1'b0);
		acc(1'b1, `SPIP_OFF_IRQ_EN, 8'h01);
		repeat (2) @(negedge clock);
		chk("irq raised", irq, 1'b1);
		acc(1'b1, `SPIP_OFF_IRQ_CLR, 8'h03);
		repeat (2) @(negedge clock);
		chk("irq cleared", irq, 1'b0);
		acc(0, `SPIP_OFF_IRQ_STAT, 8'h00);
		chk("status cleared", rv, 32'h0);
		$display("test interrupt finished");
		// slave: both capture edges with select, then select pin not used
		for (i = 0; i < 3; i++) begin
			pol = 1'b0;
			edg = i[0];
			msb = 1'b1;
			ptx = 8'h96 ^ i[7:0];
			v = 8'h3A + i[7:0];
			acc(1'b1, `SPIP_OFF_CTRL0, 8'hA2);
			acc(1'b1, `SPIP_OFF_CTRL1, {2'b00, pol, edg, msb, i < 2, 2'b00});
			acc(1'b1, `SPIP_OFF_DATA, v);
			spip_peer_i.run_master(i < 2);
			acc(0, `SPIP_OFF_CTRL1, 8'h00);
			chk("slave done", rv[0], 1'b1);
			acc(0, `SPIP_OFF_DATA, 8'h00);
			chk("slave received", rv, ptx);
			chk("slave sent", prx, v);
			acc(1'b1, `SPIP_OFF_CTRL1, 8'h00);
		end
		$display("test slave finished");
		acc(1'b1, `SPIP_OFF_CTRL0, 8'h00);
		repeat (2) @(negedge clock);
		chk("off out en", pins.serial_out_en, 1'b0);
		chk("off clk en", pins.clock_en, 1'b0);
		chk("off sel en", pins.select_n_en, 1'b0);
		$display("test port off finished");
		report_and_stop();
	end
endmodule : tb
